// ==== verilog/ccc_pkg.sv ====
// Constants, encodings and helpers for the cache coherency controller.
package ccc_pkg;
  localparam int       LINES   = 16;
  localparam int       IDX_W   = 4;
  localparam int       RGN_N   = 4;
  // Line state encoding in the two state bits.
  localparam logic [1:0] ST_I  = 2'h0;
  localparam logic [1:0] ST_S  = 2'h1;
  localparam logic [1:0] ST_E  = 2'h2;
  localparam logic [1:0] ST_M  = 2'h3;
  // Memory type codes.
  localparam logic [2:0] MT_UC = 3'h0;
  localparam logic [2:0] MT_WC = 3'h1;
  localparam logic [2:0] MT_WT = 3'h4;
  localparam logic [2:0] MT_WP = 3'h5;
  localparam logic [2:0] MT_WB = 3'h6;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PDBR = 8'h04;
  localparam logic [7:0] OFS_EXT  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RGN0 = 8'h10;
  localparam logic [7:0] OFS_RGN3 = 8'h1C;
  // Field positions.
  localparam int GDIS_BIT = 30;
  localparam int WPOL_BIT = 29;
  localparam int PGWT_BIT = 3;
  localparam int PGUC_BIT = 4;
  localparam int GPEN_BIT = 7;
  localparam int REN_BIT = 11;
  localparam int RGN_W   = 3;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PDBR_RST = 32'h0000_0000;
  localparam logic [31:0] EXT_RST  = 32'h0000_0000;
  localparam logic [15:0] FLT_CODE = 16'h0000;
  // AXI responses.
  localparam logic [1:0] RSP_OK  = 2'h0;
  localparam logic [1:0] RSP_SLV = 2'h2;
  localparam logic [1:0] RSP_DEC = 2'h3;

  // Valid lines are M, E and S.
  function automatic logic line_valid(input logic [1:0] st);
    line_valid = (st != ST_I);
  endfunction

  // Cacheable effective types.
  function automatic logic cacheable(input logic [2:0] mt);
    cacheable = (mt != MT_UC) && (mt != MT_WC);
  endfunction

  // Effective memory type from region type and page attributes.
  function automatic logic [2:0] eff_type(input logic [2:0] rt,
                                          input logic       uc,
                                          input logic       wt);
    if (uc) begin
      eff_type = MT_UC;
    end else if (wt && rt == MT_WB) begin
      eff_type = MT_WT;
    end else begin
      eff_type = rt;
    end
  endfunction

  // Byte-lane merge of a write into a register.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  typedef enum logic {W_IDLE, W_RESP} ccc_wst_t;
endpackage

// ==== verilog/ccc_top.sv ====
// Cache line coherency state keeping and cache policy control.
// Behaviour
// - Data/L2 lines hold two state bits
// - Instruction cache S/I, dropped on data writes
// - M/E/S valid; only M has stale memory
// - M/E lines are held nowhere else
// - M/E writes local for write-back or with both bits set; S both, but local only with both bits set; I bus
// - Global cache disable at control bit 30
// - Cache disable stops fills, snoops still answered
// - Cache disable still serves hits, invalidates
// - Strict order only when regions off/uncached
// - Both bits clear gives normal mode; types come from regions
// - Page cache disable with paging, global clear
// - Page write-through with paging, policy clear
// - Base register attributes govern directory only
// - Normal mode: hits cached, cacheable read misses allocate
// - Normal mode shared write may become exclusive
// - Illegal bit pair faults with code zero
// - Disabled mode coherent, no read allocation
// - Both bits set: incoherent, E becomes M
// - Global page attribute needs global enable
// - Region registers assign memory types
// - Snooped modified line: hit-modified, write back
// - Page write-through turns write-back into WT
// - Page cache disable forces uncacheable
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             acc_valid,
  input  wire logic             acc_write,
  input  wire logic             acc_fetch,
  input  wire logic [IDX_W-1:0] acc_index,
  input  wire logic             acc_pdir,
  input  wire logic             acc_page_uc,
  input  wire logic             acc_page_wt,
  input  wire logic             acc_global,
  input  wire logic [1:0]       acc_region,
  input  wire logic             acc_shared,
  input  wire logic             paging_on,
  input  wire logic             snp_valid,
  input  wire logic             snp_write,
  input  wire logic [IDX_W-1:0] snp_index,
  output logic                  acc_done,
  output logic                  acc_retry,
  output logic                  acc_hit,
  output logic                  acc_bus_read,
  output logic                  acc_bus_write,
  output logic                  acc_fill,
  output logic [2:0]            acc_mem_type,
  output logic                  acc_keep_global,
  output logic                  snp_done,
  output logic                  snp_hit,
  output logic                  snoop_hit_modified,
  output logic                  snp_writeback,
  output logic                  prot_fault,
  output logic [15:0]           prot_err_code,
  output logic                  strict_order
);

  ////////////////////////////////////////////////////////////////////
  // Storage.

  logic [1:0]       lines_reg [LINES];
  logic             ic_reg    [LINES];
  logic [31:0]      ctrl_reg;
  logic [31:0]      pdbr_reg;
  logic [31:0]      ext_reg;
  logic [RGN_W-1:0] rgn_reg   [RGN_N];
  logic [7:0]       prot_cnt_reg;
  ccc_wst_t         wst_reg;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;

  ////////////////////////////////////////////////////////////////////
  // Decoded controls.

  logic             gdis;
  logic             wpol;
  logic             mode_nn;
  logic             mode_dw;
  logic [2:0]       rtype;
  logic             page_uc;
  logic             page_wt;
  logic [2:0]       mt;
  logic             acc_go;
  logic             snp_go;
  logic [1:0]       ast;
  logic [1:0]       sst;
  logic             ahit;
  logic             wr_go;
  logic             wr_ctrl;
  logic             ctrl_bad;
  logic [31:0]      wr_val;

  // The two global bits pick one of three legal operating modes.
  assign gdis    = ctrl_reg[GDIS_BIT];
  assign wpol    = ctrl_reg[WPOL_BIT];
  assign mode_nn = !gdis && !wpol;
  assign mode_dw = gdis && wpol;

  // Regions disabled read as uncacheable, as after reset.
  assign rtype = ext_reg[REN_BIT] ? rgn_reg[acc_region] : MT_UC;

  // Page attributes count only with paging on and their control bit clear (gdis for uc, wpol for wt);
  // directory accesses take the base register attributes instead.
  assign page_uc = paging_on && !gdis &&
                   (acc_pdir ? pdbr_reg[PGUC_BIT] : acc_page_uc);
  assign page_wt = paging_on && !wpol &&
                   (acc_pdir ? pdbr_reg[PGWT_BIT] : acc_page_wt);
  assign mt      = eff_type(rtype, page_uc, page_wt);

  // A snoop and an access in the same cycle: the snoop wins and the
  // access is told to retry, so the array never sees two updates.
  assign snp_go = ce && snp_valid;
  assign acc_go = ce && acc_valid && !snp_valid;
  assign ast    = lines_reg[acc_index];
  assign sst    = lines_reg[snp_index];
  assign ahit   = acc_fetch ? ic_reg[acc_index] : line_valid(ast);

  ////////////////////////////////////////////////////////////////////
  // Data and second-level line states.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LINES; i++) begin
        lines_reg[i] <= ST_I;
      end
    end else if (snp_go) begin
      // Snoop invalidation is inhibited when coherency is off.
      if (!mode_dw) begin
        if (snp_write) begin
          lines_reg[snp_index] <= ST_I;
        end else if (line_valid(sst)) begin
          lines_reg[snp_index] <= ST_S;
        end
      end
    end else if (acc_go && !acc_fetch) begin
      if (acc_write) begin
        if (mode_dw) begin
          if (ast == ST_E) begin
            lines_reg[acc_index] <= ST_M;
          end
        end else if (line_valid(ast) && !cacheable(mt)) begin
          lines_reg[acc_index] <= ST_I;
        end else if (ast == ST_E && mt == MT_WB) begin
          lines_reg[acc_index] <= ST_M;
        end else if (ast == ST_S && mode_nn && mt == MT_WB) begin
          lines_reg[acc_index] <= ST_E;
        end
      end else if (ast == ST_I && mode_nn && cacheable(mt)) begin
        lines_reg[acc_index] <= acc_shared ? ST_S : ST_E;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Instruction cache valid bits; only shared or invalid.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LINES; i++) begin
        ic_reg[i] <= 1'b0;
      end
    end else if (snp_go) begin
      if (snp_write) begin
        ic_reg[snp_index] <= 1'b0;
      end
    end else if (acc_go) begin
      if (acc_write) begin
        ic_reg[acc_index] <= 1'b0;
      end else if (acc_fetch && mode_nn && cacheable(mt)) begin
        ic_reg[acc_index] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Access answers, one cycle after the request.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_done        <= 1'b0;
      acc_retry       <= 1'b0;
      acc_hit         <= 1'b0;
      acc_bus_read    <= 1'b0;
      acc_bus_write   <= 1'b0;
      acc_fill        <= 1'b0;
      acc_mem_type    <= MT_UC;
      acc_keep_global <= 1'b0;
    end else if (ce) begin
      acc_done        <= acc_go;
      acc_retry       <= acc_valid && snp_valid;
      acc_hit         <= acc_go && ahit;
      acc_mem_type    <= acc_go ? mt : acc_mem_type;
      acc_keep_global <= acc_go && acc_global &&
                         ext_reg[GPEN_BIT];
      // Reads miss to the bus; only the normal mode allocates.
      acc_bus_read    <= acc_go && !acc_write && !ahit;
      acc_fill        <= acc_go && !acc_write && !ahit &&
                         mode_nn && cacheable(mt);
      if (!acc_go || !acc_write) begin
        acc_bus_write <= 1'b0;
      end else if (mode_dw) begin
        acc_bus_write <= !line_valid(ast);
      end else if (ast == ST_I || ast == ST_S) begin
        acc_bus_write <= 1'b1;
      end else begin
        acc_bus_write <= !cacheable(mt) || mt != MT_WB;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Snoop answers are given in every mode.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snp_done           <= 1'b0;
      snp_hit            <= 1'b0;
      snoop_hit_modified <= 1'b0;
      snp_writeback      <= 1'b0;
    end else if (ce) begin
      snp_done           <= snp_go;
      snp_hit            <= snp_go && line_valid(sst);
      snoop_hit_modified <= snp_go && sst == ST_M;
      snp_writeback      <= snp_go && sst == ST_M;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels; address and data in either order.

  assign wr_go    = ce && aw_held_reg && w_held_reg && wst_reg == W_IDLE;
  assign wr_ctrl  = awaddr_reg == OFS_CTRL;
  assign wr_val   = merge(ctrl_reg, wdata_reg, wstrb_reg);
  assign ctrl_bad = !wr_val[GDIS_BIT] && wr_val[WPOL_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_reg       <= W_IDLE;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RSP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (wst_reg)
        W_IDLE: begin
          if (wr_go) begin
            wst_reg      <= W_RESP;
            s_axi_bvalid <= 1'b1;
            if (wr_ctrl && ctrl_bad) begin
              s_axi_bresp <= RSP_SLV;
            end else if (awaddr_reg == OFS_STAT ||
                         awaddr_reg[1:0] != 2'h0 ||
                         awaddr_reg > OFS_RGN3) begin
              s_axi_bresp <= RSP_DEC;
            end else begin
              s_axi_bresp <= RSP_OK;
            end
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            wst_reg       <= W_IDLE;
            s_axi_bvalid  <= 1'b0;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
        default: begin
          wst_reg <= W_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file; a rejected control write leaves it untouched.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      pdbr_reg <= PDBR_RST;
      ext_reg  <= EXT_RST;
      for (int i = 0; i < RGN_N; i++) begin
        rgn_reg[i] <= MT_UC;
      end
    end else if (wr_go) begin
      if (wr_ctrl) begin
        if (!ctrl_bad) begin
          ctrl_reg <= wr_val;
        end
      end else if (awaddr_reg == OFS_PDBR) begin
        pdbr_reg <= merge(pdbr_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == OFS_EXT) begin
        ext_reg <= merge(ext_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg >= OFS_RGN0 && awaddr_reg <= OFS_RGN3 &&
                   awaddr_reg[1:0] == 2'h0 && wstrb_reg[0]) begin
        rgn_reg[awaddr_reg[3:2]] <= wdata_reg[RGN_W-1:0];
      end
    end
  end

  // Fault pulse and running count of rejected control loads.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_fault    <= 1'b0;
      prot_err_code <= FLT_CODE;
      prot_cnt_reg  <= 8'h00;
    end else if (ce) begin
      prot_fault    <= wr_go && wr_ctrl && ctrl_bad;
      prot_err_code <= FLT_CODE;
      if (wr_go && wr_ctrl && ctrl_bad) begin
        prot_cnt_reg <= prot_cnt_reg + 8'h01;
      end
    end
  end

  // Strict ordering is not implied by the cache-disable bit itself.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strict_order <= 1'b1;
    end else if (ce) begin
      strict_order <= !ext_reg[REN_BIT] ||
                      (rgn_reg[0] == MT_UC && rgn_reg[1] == MT_UC &&
                       rgn_reg[2] == MT_UC && rgn_reg[3] == MT_UC);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; one outstanding read.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RSP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RSP_OK;
        s_axi_rdata   <= 32'h0000_0000;
        if (s_axi_araddr == OFS_CTRL) begin
          s_axi_rdata <= ctrl_reg;
        end else if (s_axi_araddr == OFS_PDBR) begin
          s_axi_rdata <= pdbr_reg;
        end else if (s_axi_araddr == OFS_EXT) begin
          s_axi_rdata <= ext_reg;
        end else if (s_axi_araddr == OFS_STAT) begin
          s_axi_rdata <= {prot_err_code, 7'h00, strict_order,
                          prot_cnt_reg};
        end else if (s_axi_araddr >= OFS_RGN0 &&
                     s_axi_araddr <= OFS_RGN3 &&
                     s_axi_araddr[1:0] == 2'h0) begin
          s_axi_rdata <= {29'h0, rgn_reg[s_axi_araddr[3:2]]};
        end else begin
          s_axi_rresp <= RSP_DEC;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_prot;
    wr_go && wr_ctrl && ctrl_bad |=>
      prot_fault && s_axi_bresp == RSP_SLV && ctrl_reg == $past(ctrl_reg);
  endproperty
  a_prot: assert property (p_prot) else $error("illegal load not faulted");

  property p_snphm;
    snp_go && sst == ST_M |=> snoop_hit_modified && snp_writeback;
  endproperty
  a_snphm: assert property (p_snphm) else $error("no hit-modified");

  property p_local;
    acc_go && acc_write && !acc_fetch && (ast == ST_M || ast == ST_E) &&
      mt == MT_WB && !gdis |=> !acc_bus_write;
  endproperty
  a_local: assert property (p_local) else $error("local write hit bus");

  property p_sbus;
    acc_go && acc_write && !mode_dw && (ast == ST_S || ast == ST_I)
      |=> acc_bus_write && acc_done;
  endproperty
  a_sbus: assert property (p_sbus) else $error("write missed bus");

  property p_nofill;
    acc_go && gdis && !acc_write |=> !acc_fill;
  endproperty
  a_nofill: assert property (p_nofill) else $error("fill while disabled");

  property p_e2m;
    acc_go && mode_dw && acc_write && !acc_fetch && ast == ST_E
      |=> lines_reg[$past(acc_index)] == ST_M && !acc_bus_write;
  endproperty
  a_e2m: assert property (p_e2m) else $error("E not made M");

  property p_pageuc;
    acc_go && paging_on && !gdis && !acc_pdir && acc_page_uc
      |=> acc_mem_type == MT_UC;
  endproperty
  a_pageuc: assert property (p_pageuc) else $error("page disable ignored");

  property p_icinv;
    acc_go && acc_write |=> !ic_reg[$past(acc_index)];
  endproperty
  a_icinv: assert property (p_icinv) else $error("icache kept stale");

  property p_snpinv;
    snp_go && snp_write && !mode_dw |=> lines_reg[$past(snp_index)] == ST_I;
  endproperty
  a_snpinv: assert property (p_snpinv) else $error("snoop no invalidate");

endmodule

// ==== tb/ccc_snoop_agent.sv ====
// Bus agent that snoops lines held by the cache coherency controller.
`timescale 1ns/1ps
module ccc_snoop_agent (
  input  wire logic       clk,
  input  wire logic       snp_hit,
  input  wire logic       snoop_hit_modified,
  output logic            snp_valid,
  output logic            snp_write,
  output logic [3:0]      snp_index
);
  // The agent starts idle with a junk index on the bus.
  initial begin
    snp_valid = 1'h0;
    snp_write = 1'h0;
    snp_index = 4'hA;
  end

  // One snoop; the index is inverted on release so a stale value is never trusted.
  task automatic snoop(input logic w, input logic [3:0] i, output logic h, output logic m);
    @(posedge clk);
    snp_valid <= 1'h1;
    snp_write <= w;
    snp_index <= i;
    @(posedge clk);
    snp_valid <= 1'h0;
    snp_index <= ~i;
    #1;
    h = snp_hit;
    m = snoop_hit_modified;
  endtask
endmodule

// ==== tb/test_cache_coherency_control.sv ====
// Self-checking bench for the cache coherency controller.
`timescale 1ns/1ps
module test_cache_coherency_control;
  import ccc_pkg::*;
  logic clk, rst_n, ce, paging_on, h, m;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, acc_index, snp_index, o;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, acc_region, r;
  logic acc_valid, acc_write, acc_fetch, acc_pdir, acc_page_uc, acc_page_wt;
  logic acc_global, acc_shared;
  logic acc_done, acc_hit, acc_bus_read, acc_bus_write, acc_fill, strict_order;
  logic acc_retry, acc_keep_global, snp_writeback, prot_fault;
  logic snp_valid, snp_write, snp_done, snp_hit, snoop_hit_modified;
  logic [2:0] acc_mem_type;
  logic [15:0] prot_err_code;
  int num_errors = 0;
  int num_checks = 0;

  ccc_top DUT (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_write, .acc_fetch,
    .acc_index, .acc_pdir, .acc_page_uc, .acc_page_wt, .acc_global, .acc_region, .acc_shared,
    .paging_on, .snp_valid, .snp_write, .snp_index, .acc_done, .acc_retry, .acc_hit,
    .acc_bus_read, .acc_bus_write, .acc_fill, .acc_mem_type, .acc_keep_global,
    .snp_done, .snp_hit, .snoop_hit_modified, .snp_writeback, .prot_fault,
    .prot_err_code, .strict_order);
  ccc_snoop_agent agt (.clk, .snp_hit, .snoop_hit_modified, .snp_valid, .snp_write,
    .snp_index);

  ////////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 25 ns.
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // The watchdog ends a hung run long after the tests should be over.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register write; bready stays up from the start so the answer is never missed.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // Register read; data and response are taken at the rvalid edge.
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Core access for one cycle; result bits are hit, bus read, bus write, fill.
  task automatic acc(input logic w, input logic [3:0] i, input logic pc, input logic pw);
    int n;
    n = 0;
    @(posedge clk);
    acc_valid <= 1'h1;
    acc_write <= w;
    acc_index <= i;
    acc_page_uc <= pc;
    acc_page_wt <= pw;
    acc_region <= 2'h0;
    @(posedge clk);
    acc_valid <= 1'h0;
    acc_index <= ~i;
    acc_region <= 2'h3;
    #1;
    while (acc_done !== 1'h1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    o = {acc_hit, acc_bus_read, acc_bus_write, acc_fill};
    chk("acc_done", 32'h1, acc_done);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register checks, then each cache mode in turn.
  initial begin
    {rst_n, paging_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, acc_valid, acc_write, acc_fetch} = '0;
    {acc_pdir, acc_page_uc, acc_page_wt, acc_shared, acc_region} = '0;
    acc_global = 1'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acc_index} = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    axr(OFS_CTRL);
    chk("ctrl", CTRL_RST, d);
    chk("strict", 32'h1, strict_order);
    axw(OFS_CTRL, 32'h2000_0000);
    chk("bresp", RSP_SLV, r);
    chk("fault", 32'h1, prot_fault);
    chk("fault_code", FLT_CODE, prot_err_code);
    axr(OFS_CTRL);
    chk("ctrl", 32'h0, d);
    axw(8'h20, 32'h0);
    chk("bresp", RSP_DEC, r);
    axw(OFS_EXT, 32'h0000_0880);
    axw(OFS_RGN0, 32'h6);
    // The ordering flag follows the region table one cycle after the write lands.
    #1;
    chk("strict", 32'h0, strict_order);
    acc(1'h0, 4'h1, 1'h0, 1'h0);
    chk("acc", 32'h5, o);
    chk("keep_global", 32'h1, acc_keep_global);
    acc(1'h1, 4'h1, 1'h0, 1'h0);
    chk("acc", 32'h8, o);
    agt.snoop(1'h0, 4'h1, h, m);
    chk("snp_hm", 32'h1, m);
    chk("snp_wb", 32'h1, snp_writeback);
    chk("snp_done", 32'h1, snp_done);
    acc(1'h1, 4'h1, 1'h0, 1'h0);
    chk("acc", 32'hA, o);
    acc(1'h1, 4'h1, 1'h0, 1'h0);
    chk("acc", 32'h8, o);
    acc(1'h1, 4'h2, 1'h0, 1'h0);
    chk("acc", 32'h2, o);
    // Instruction fetches fill the instruction cache; a data write drops the copy.
    acc_fetch <= 1'h1;
    acc(1'h0, 4'h5, 1'h0, 1'h0);
    chk("fetch", 32'h5, o);
    acc(1'h0, 4'h5, 1'h0, 1'h0);
    chk("fetch", 32'h8, o);
    acc_fetch <= 1'h0;
    acc(1'h1, 4'h5, 1'h0, 1'h0);
    chk("acc", 32'h2, o);
    acc_fetch <= 1'h1;
    acc(1'h0, 4'h5, 1'h0, 1'h0);
    chk("fetch", 32'h5, o);
    acc_fetch <= 1'h0;
    paging_on <= 1'h1;
    acc(1'h0, 4'h3, 1'h1, 1'h0);
    chk("acc", 32'h4, o);
    chk("type", MT_UC, acc_mem_type);
    acc(1'h0, 4'h3, 1'h0, 1'h1);
    chk("type", MT_WT, acc_mem_type);
    chk("acc", 32'h5, o);
    // Directory accesses take the base register attributes, not the page ones.
    axw(OFS_PDBR, 32'h0000_0010);
    acc_pdir <= 1'h1;
    acc(1'h0, 4'h6, 1'h0, 1'h1);
    chk("type", MT_UC, acc_mem_type);
    acc_pdir <= 1'h0;
    // Both control bits set: writes to valid lines stay local and snoops do not invalidate.
    axw(OFS_CTRL, 32'h6000_0000);
    chk("bresp", RSP_OK, r);
    acc(1'h1, 4'h3, 1'h0, 1'h0);
    chk("acc", 32'h8, o);
    agt.snoop(1'h1, 4'h3, h, m);
    chk("snp_hm", 32'h1, m);
    acc(1'h0, 4'h3, 1'h0, 1'h0);
    chk("acc", 32'h8, o);
    // Cache disable alone: hits served, no allocation, snoops still answered.
    axw(OFS_CTRL, 32'h4000_0000);
    acc(1'h0, 4'h4, 1'h0, 1'h0);
    chk("acc", 32'h4, o);
    acc(1'h0, 4'h3, 1'h1, 1'h0);
    chk("acc", 32'h8, o);
    chk("type", MT_WB, acc_mem_type);
    agt.snoop(1'h1, 4'h3, h, m);
    chk("snp_hit", 32'h1, h);
    acc(1'h0, 4'h3, 1'h0, 1'h0);
    chk("acc", 32'h4, o);
    // An access that meets a snoop in the same cycle is refused and told to retry.
    fork
      agt.snoop(1'h0, 4'h7, h, m);
      begin
        @(posedge clk);
        acc_valid <= 1'h1;
        @(posedge clk);
        acc_valid <= 1'h0;
        #1;
        chk("retry", 32'h1, acc_retry);
        chk("acc_done", 32'h0, acc_done);
      end
    join
    stop_test;
  end
endmodule
